/* sgc_regs.vh */
// register map and constants of the gain/agc/auto-zero block
// assumes an 8-bit register port and a 125 MHz system clock
`ifndef SGC_REGS_VH
`define SGC_REGS_VH
`define SGC_ADDR_GAIN      8'haa
`define SGC_ADDR_HYST      8'hb3
`define SGC_ADDR_AZ        8'hd6
`define SGC_ADDR_CTRL      8'h80
`define SGC_ADDR_CFG8      8'hb1
`define SGC_ADDR_STAT      8'he0
`define SGC_RST_GAIN       5'h09
`define SGC_RST_HIGH_SEL   2'h3
`define SGC_RST_LOW_SEL    2'h3
`define SGC_RST_PERS       3'h2
`define SGC_RST_AZ         8'hff
`define SGC_GAIN_MAX       5'h0a
`define SGC_AZ_NEVER       8'h00
`define SGC_AZ_FIRST_ONLY  8'hff
`define SGC_FLICKER_DETECT_ENABLE_BIT       0
`define SGC_SPECTRAL_GAIN_AUTO_ENABLE_BIT     2
`define SGC_GAIN_MSB       4
`define SGC_HIGH_MSB       7
`define SGC_HIGH_LSB       6
`define SGC_LOW_MSB        5
`define SGC_LOW_LSB        4
`define SGC_PERS_MSB       2
`define SGC_AZ_TIME_US     15000
`define SGC_CLK_MHZ        125
`endif

/* sgc_cfg.v */
// gain, automatic gain control, flicker persistence and auto-zero scheduler
// assumes strobes and inputs from logic on clk_sys; flicker result is a pin
//
// Contract
// - gain code n gives 2^(n-1) gain, codes 0 to 10, common to channels
// - configuration serves all six channels: gain, agc enable, auto-zero (code zeroes the sixth only with flicker enabled)
// - agc lowers gain when data reaches high threshold 50..87.5 percent
// - agc raises gain when data falls to low threshold 12.5..50 percent
// - thresholds are fractions of (step count+1)*(step size+1)
// - flicker status changes after 2^(p-1) consecutive differing results
// - auto-zero interval: 0 never, n every n cycles, 255 before first only
// - with flicker enabled, zero sixth adc, abort and restart flicker
// - one auto-zero pass lasts about 15 ms
// - spectral agc runs only while its enable bit 2 is set
// - flicker enable at 0x80; when clear sixth adc follows other five
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "sgc_regs.vh"
module sgc_cfg #(
   parameter AZ_CYCLES = (`SGC_AZ_TIME_US * `SGC_CLK_MHZ),
   parameter NCH       = 6
) (
   input  wire         clk_sys,
   input  wire         arst_n,
   input  wire         clk_en,
   input  wire [7:0]   reg_addr,
   input  wire [7:0]   reg_wdata,
   input  wire         reg_wr,
   input  wire         reg_rd,
   output reg  [7:0]   reg_rdata_ff,
   input  wire         meas_start,
   input  wire         meas_done,
   input  wire [15:0]  chan_max_data,
   input  wire [7:0]   integration_step_count,
   input  wire [15:0]  integration_step_size,
   input  wire         flicker_result,
   input  wire         flicker_result_valid,
   output reg  [4:0]   spectral_gain_code_ff,
   output reg  [4:0]   sixth_gain_code_ff,
   output reg          sixth_follows_ff,
   output reg          flicker_status_ff,
   output reg          flicker_event_ff,
   output reg          autozero_busy_ff,
   output reg  [NCH-1:0] autozero_chan_ff,
   output reg          flicker_restart_ff
);
   localparam ST_IDLE = 3'b001;
   localparam ST_AZ   = 3'b010;
   localparam ST_RUN  = 3'b100;

   reg [1:0]  high_sel_ff;
   reg [1:0]  low_sel_ff;
   reg [2:0]  flicker_persistence_ff;
   reg [7:0]  offset_zeroing_interval_ff;
   reg        flicker_detect_enable_ff;
   reg        spectral_gain_auto_enable_ff;
   reg [2:0]  state_ff;
   reg [7:0]  cycle_cnt_ff;
   reg        first_done_ff;
   reg [31:0] az_cnt_ff;
   reg [7:0]  pers_cnt_ff;
   reg        fr_meta_ff;
   reg        fr_sync_ff;
   reg        frv_meta_ff;
   reg        frv_sync_ff;
   reg        frv_prev_ff;
   reg        az_fd_ff;
   reg        az_due;
   wire [NCH-1:0] az_req;
   genvar     k;

   // full-scale count and the two thresholds in eighths
   wire [24:0] full_scale = {16'h0000, integration_step_count} + 25'h1;
   wire [16:0] step_p1    = {1'b0, integration_step_size} + 17'h1;
   wire [41:0] fs_count   = full_scale * step_p1;
   wire [44:0] data_x8    = {chan_max_data, 3'b000};
   wire [3:0]  high_frac  = {2'b00, high_sel_ff} + 4'h4;
   wire [3:0]  low_frac   = {2'b00, low_sel_ff} + 4'h1;
   wire [45:0] high_th    = fs_count * high_frac;
   wire [45:0] low_th     = fs_count * low_frac;
   wire        at_high    = {1'b0, data_x8} >= high_th;
   wire        at_low     = {1'b0, data_x8} <= low_th;
   wire [7:0]  pers_need  = pers_len(flicker_persistence_ff);
   wire        frv_rise   = frv_sync_ff & ~frv_prev_ff;

   // due check widened so a count of 255 cannot wrap back to zero
   always @*
   begin
      az_due = 1'b0;
      if (offset_zeroing_interval_ff == `SGC_AZ_FIRST_ONLY)
         az_due = ~first_done_ff;
      else if (offset_zeroing_interval_ff != `SGC_AZ_NEVER)
         az_due = (({1'b0, cycle_cnt_ff} + 9'h001) >=
                   {1'b0, offset_zeroing_interval_ff});
   end

   // channels zeroed per pass: spectral always, sixth only with flicker on
   generate
      for (k = 0; k < NCH; k = k + 1)
      begin : g_az_req
         if (k == NCH - 1)
         begin : g_sixth
            assign az_req[k] = flicker_detect_enable_ff;
         end
         else
         begin : g_spec
            assign az_req[k] = 1'b1;
         end
      end
   endgenerate

   // results needed in a row; p of zero treated as one
   function [7:0] pers_len;
      input [2:0] p;
      begin
         if (p == 3'h0)
            pers_len = 8'h01;
         else
            pers_len = 8'h01 << (p - 3'h1);
      end
   endfunction

   function sel;
      input [7:0] a;
      input [7:0] b;
      begin
         sel = (a == b);
      end
   endfunction

   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         spectral_gain_code_ff        <= `SGC_RST_GAIN;
         high_sel_ff                  <= `SGC_RST_HIGH_SEL;
         low_sel_ff                   <= `SGC_RST_LOW_SEL;
         flicker_persistence_ff       <= `SGC_RST_PERS;
         offset_zeroing_interval_ff   <= `SGC_RST_AZ;
         flicker_detect_enable_ff     <= 1'b0;
         spectral_gain_auto_enable_ff <= 1'b0;
         reg_rdata_ff                 <= 8'h00;
      end
      else if (clk_en)
      begin
         reg_rdata_ff <= 8'h00;
         if (reg_wr)
         begin
            if (sel(reg_addr, `SGC_ADDR_GAIN))
               spectral_gain_code_ff <= reg_wdata[`SGC_GAIN_MSB:0];
            else if (sel(reg_addr, `SGC_ADDR_HYST))
            begin
               high_sel_ff <= reg_wdata[`SGC_HIGH_MSB:`SGC_HIGH_LSB];
               low_sel_ff  <= reg_wdata[`SGC_LOW_MSB:`SGC_LOW_LSB];
               flicker_persistence_ff <= reg_wdata[`SGC_PERS_MSB:0];
            end
            else if (sel(reg_addr, `SGC_ADDR_AZ))
               offset_zeroing_interval_ff <= reg_wdata;
            else if (sel(reg_addr, `SGC_ADDR_CTRL))
               flicker_detect_enable_ff <= reg_wdata[`SGC_FLICKER_DETECT_ENABLE_BIT];
            else if (sel(reg_addr, `SGC_ADDR_CFG8))
               spectral_gain_auto_enable_ff <=
                  reg_wdata[`SGC_SPECTRAL_GAIN_AUTO_ENABLE_BIT];
         end
         else if (meas_done && spectral_gain_auto_enable_ff)
         begin
            if (at_high && spectral_gain_code_ff != 5'h00)
               spectral_gain_code_ff <= spectral_gain_code_ff - 5'h1;
            else if (at_low && spectral_gain_code_ff < `SGC_GAIN_MAX)
               spectral_gain_code_ff <= spectral_gain_code_ff + 5'h1;
         end
         if (reg_rd)
         begin
            if (sel(reg_addr, `SGC_ADDR_GAIN))
               reg_rdata_ff <= {3'b000, spectral_gain_code_ff};
            else if (sel(reg_addr, `SGC_ADDR_HYST))
               reg_rdata_ff <= {high_sel_ff, low_sel_ff, 1'b0,
                                flicker_persistence_ff};
            else if (sel(reg_addr, `SGC_ADDR_AZ))
               reg_rdata_ff <= offset_zeroing_interval_ff;
            else if (sel(reg_addr, `SGC_ADDR_CTRL))
               reg_rdata_ff <= {7'h00, flicker_detect_enable_ff};
            else if (sel(reg_addr, `SGC_ADDR_CFG8))
               reg_rdata_ff <= {5'h00, spectral_gain_auto_enable_ff, 2'b00};
            else if (sel(reg_addr, `SGC_ADDR_STAT))
               reg_rdata_ff <= {5'h00, autozero_busy_ff, flicker_status_ff,
                                first_done_ff};
         end
      end
   end

   // sixth channel copies the common gain every enabled cycle; sixth_follows_ff is set while flicker detection is off
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sixth_gain_code_ff <= `SGC_RST_GAIN;
         sixth_follows_ff   <= 1'b1;
      end
      else if (clk_en)
      begin
         sixth_follows_ff   <= ~flicker_detect_enable_ff;
         sixth_gain_code_ff <= spectral_gain_code_ff;
      end
   end

   // flicker persistence filter, result is a pin so synchronised first
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fr_meta_ff        <= 1'b0;
         fr_sync_ff        <= 1'b0;
         frv_meta_ff       <= 1'b0;
         frv_sync_ff       <= 1'b0;
         frv_prev_ff       <= 1'b0;
         pers_cnt_ff       <= 8'h00;
         flicker_status_ff <= 1'b0;
         flicker_event_ff  <= 1'b0;
      end
      else if (clk_en)
      begin
         fr_meta_ff       <= flicker_result;
         fr_sync_ff       <= fr_meta_ff;
         frv_meta_ff      <= flicker_result_valid;
         frv_sync_ff      <= frv_meta_ff;
         frv_prev_ff      <= frv_sync_ff;
         flicker_event_ff <= 1'b0;
         if (frv_rise)
         begin
            if (fr_sync_ff == flicker_status_ff)
               pers_cnt_ff <= 8'h00;
            else if (pers_cnt_ff + 8'h1 >= pers_need)
            begin
               flicker_status_ff <= fr_sync_ff;
               flicker_event_ff  <= 1'b1;
               pers_cnt_ff       <= 8'h00;
            end
            else
               pers_cnt_ff <= pers_cnt_ff + 8'h1;
         end
      end
   end

   // auto-zero scheduler
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_ff           <= ST_IDLE;
         cycle_cnt_ff       <= 8'h00;
         first_done_ff      <= 1'b0;
         az_cnt_ff          <= 32'h0;
         az_fd_ff           <= 1'b0;
         autozero_busy_ff   <= 1'b0;
         autozero_chan_ff   <= {NCH{1'b0}};
         flicker_restart_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         flicker_restart_ff <= 1'b0;
         case (state_ff)
            ST_IDLE:
               if (meas_start)
               begin
                  if (az_due)
                  begin
                     state_ff         <= ST_AZ;
                     az_cnt_ff        <= 32'h0;
                     autozero_busy_ff <= 1'b1;
                     cycle_cnt_ff     <= 8'h00;
                     az_fd_ff         <= flicker_detect_enable_ff;
                     autozero_chan_ff <= az_req;
                  end
                  else
                  begin
                     state_ff <= ST_RUN;
                     if (offset_zeroing_interval_ff != `SGC_AZ_NEVER)
                        cycle_cnt_ff <= cycle_cnt_ff + 8'h1;
                  end
               end
            ST_AZ:
               if (az_cnt_ff >= AZ_CYCLES - 1)
               begin
                  state_ff           <= ST_RUN;
                  autozero_busy_ff   <= 1'b0;
                  autozero_chan_ff   <= {NCH{1'b0}};
                  first_done_ff      <= 1'b1;
                  flicker_restart_ff <= az_fd_ff;
               end
               else
                  az_cnt_ff <= az_cnt_ff + 32'h1;
            ST_RUN:
               if (meas_done)
               begin
                  state_ff      <= ST_IDLE;
                  first_done_ff <= 1'b1;
               end
            default:
               state_ff <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

/* sgc_cfg_props.sv */
// assertions on the ports of the gain/agc/auto-zero block
// bound to sgc_cfg from the bench top file
`timescale 1ns/1ps
`default_nettype none
module sgc_cfg_props #(
   parameter AZ_CYCLES = 20
) (
   input wire       clk_sys,
   input wire       arst_n,
   input wire       clk_en,
   input wire       reg_wr,
   input wire       meas_done,
   input wire [4:0] spectral_gain_code_ff,
   input wire [4:0] sixth_gain_code_ff,
   input wire       sixth_follows_ff,
   input wire       flicker_event_ff,
   input wire       autozero_busy_ff,
   input wire [5:0] autozero_chan_ff,
   input wire       flicker_restart_ff
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   reg [31:0] busy_cnt_ff;
   always @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
         busy_cnt_ff <= 32'h0;
      else
         busy_cnt_ff <= autozero_busy_ff ? busy_cnt_ff + 32'h1 : 32'h0;
   a_gain_in_range:
      assert property (spectral_gain_code_ff <= 5'h0a)
      else $error("gain code above ten");
   a_sixth_tracks:
      assert property ($past(clk_en) |->
         sixth_gain_code_ff == $past(spectral_gain_code_ff))
      else $error("sixth gain not a copy of gain");
   a_gain_cause:
      assert property ($changed(spectral_gain_code_ff) |->
         $past(meas_done) || $past(reg_wr))
      else $error("gain moved without cause");
   a_agc_one_step:
      assert property (meas_done && !reg_wr |=> (spectral_gain_code_ff
         - $past(spectral_gain_code_ff) + 5'h1) <= 5'h2)
      else $error("gain moved more than one step");
   a_az_chans:
      assert property (autozero_busy_ff |->
         autozero_chan_ff == {!sixth_follows_ff, 5'h1f})
      else $error("wrong channels zeroed");
   a_restart_end:
      assert property (flicker_restart_ff |-> $past(autozero_busy_ff)
         && !autozero_busy_ff && !sixth_follows_ff)
      else $error("restart outside auto-zero end");
   a_az_length:
      assert property ($fell(autozero_busy_ff) |-> busy_cnt_ff == AZ_CYCLES)
      else $error("auto-zero length wrong");
   a_event_pulse:
      assert property (flicker_event_ff |=> !flicker_event_ff)
      else $error("flicker event longer than one cycle");
endmodule
`default_nettype wire

/* sgc_flk_model.sv */
// flicker result source standing in for the flicker engine
// one result per send pulse; line inverts once released
`timescale 1ns/1ps
`default_nettype none
module sgc_flk_model (
   input  wire clk_sys,
   input  wire send,
   input  wire value,
   output reg  flicker_result = 1'b0,
   output reg  flicker_result_valid = 1'b0
);
   reg [2:0] hold_ff = 3'h0;
   always @(posedge clk_sys)
      if (send)
      begin
         flicker_result       <= value;
         flicker_result_valid <= 1'b1;
         hold_ff              <= 3'h4;
      end
      else if (hold_ff != 3'h0)
      begin
         hold_ff <= hold_ff - 3'h1;
         if (hold_ff == 3'h1)
         begin
            flicker_result_valid <= 1'b0;
            flicker_result       <= ~flicker_result;
         end
      end
endmodule
`default_nettype wire

/* tb_sgc_cfg.sv */
// self-checking bench for the gain/agc/auto-zero block
// drives register port, measurement pulses and flicker model
`timescale 1ns/1ps
`default_nettype none
module tb_sgc_cfg;
   localparam AZ_CYCLES = 20;
   reg clk_sys = 1'b0, arst_n = 1'b0, clk_en = 1'b1;
   reg [7:0] reg_addr = 8'h0, reg_wdata = 8'h0, step_cnt = 8'h0f;
   reg reg_wr = 1'b0, reg_rd = 1'b0, meas_start = 1'b0, meas_done = 1'b0;
   reg [15:0] chan_max_data = 16'h0, step_sz = 16'h0fff, d;
   reg send = 1'b0, sval = 1'b0;
   reg [4:0] exp_g = 5'h09;
   reg [1:0] hs = 2'h3, ls = 2'h3;
   integer seed = 32'ha2734af1, i, restarts = 0, failures = 0, events = 0;
   integer check_count = 0;
   wire [7:0] reg_rdata_ff;
   wire [4:0] gain, sixth;
   wire fres, fval, follows, status, busy, restart, evt;
   wire [5:0] chans;
   sgc_cfg #(.AZ_CYCLES(AZ_CYCLES)) i_sgc_cfg (.clk_sys(clk_sys),
      .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_ff(reg_rdata_ff), .meas_start(meas_start),
      .meas_done(meas_done), .chan_max_data(chan_max_data),
      .integration_step_count(step_cnt), .integration_step_size(step_sz),
      .flicker_result(fres), .flicker_result_valid(fval),
      .spectral_gain_code_ff(gain), .sixth_gain_code_ff(sixth),
      .sixth_follows_ff(follows), .flicker_status_ff(status),
      .flicker_event_ff(evt), .autozero_busy_ff(busy),
      .autozero_chan_ff(chans), .flicker_restart_ff(restart));
   sgc_flk_model i_sgc_flk_model (.clk_sys(clk_sys), .send(send),
      .value(sval), .flicker_result(fres), .flicker_result_valid(fval));
   initial
      forever #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      if (restart === 1'b1)
         restarts = restarts + 1;
      if (evt === 1'b1)
         events = events + 1;
   end
   task chk(input [7:0] got, input [7:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp)
         begin
            failures = failures + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] v);
      begin
         @(posedge clk_sys);
         reg_addr  <= a;
         reg_wdata <= v;
         reg_wr    <= 1'b1;
         @(posedge clk_sys);
         reg_wr <= 1'b0;
      end
   endtask
   task rdc(input [7:0] a, input [7:0] e);
      begin
         @(posedge clk_sys);
         reg_addr <= a;
         reg_rd   <= 1'b1;
         @(posedge clk_sys);
         reg_rd <= 1'b0;
         #1 chk(reg_rdata_ff, e);
      end
   endtask
   function [4:0] agc_next(input [15:0] dv);
      reg [39:0] fs;
      begin
         fs = ({32'h0, step_cnt} + 40'h1) * ({24'h0, step_sz} + 40'h1);
         agc_next = exp_g;
         if ({24'h0, dv} * 40'h8 >= fs * (40'h4 + hs))
            agc_next = (exp_g == 5'h0) ? exp_g : exp_g - 5'h1;
         else if ({24'h0, dv} * 40'h8 <= fs * (40'h1 + ls))
            agc_next = (exp_g == 5'h0a) ? exp_g : exp_g + 5'h1;
      end
   endfunction
   task md(input [15:0] dv, input on);
      begin
         if (on)
            exp_g = agc_next(dv);
         @(posedge clk_sys);
         chan_max_data <= dv;
         meas_done     <= 1'b1;
         @(posedge clk_sys);
         meas_done <= 1'b0;
         #1 chk({3'h0, gain}, {3'h0, exp_g});
      end
   endtask
   task az(input [5:0] ch);
      begin
         @(posedge clk_sys);
         meas_start <= 1'b1;
         @(posedge clk_sys);
         meas_start <= 1'b0;
         repeat (4) if (busy !== 1'b1) @(posedge clk_sys);
         #1 chk({2'h0, chans}, {2'h0, ch});
         repeat (AZ_CYCLES + 8) if (busy !== 1'b0) @(posedge clk_sys);
         // end the measurement cycle so the scheduler returns to idle
         @(posedge clk_sys);
         meas_done <= 1'b1;
         @(posedge clk_sys);
         meas_done <= 1'b0;
         #1;
      end
   endtask
   task fl(input v);
      begin
         @(posedge clk_sys);
         send <= 1'b1;
         sval <= v;
         @(posedge clk_sys);
         send <= 1'b0;
         repeat (12) @(posedge clk_sys);
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d failures %0d", check_count, failures);
         if (failures == 0 && check_count > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial
   begin
      #(20000 * 8);
      failures = failures + 1;
      complete_run;
   end
   initial
   begin
      repeat (10) @(posedge clk_sys);
      arst_n <= 1'b1;
      rdc(8'haa, 8'h09);
      rdc(8'hb3, 8'hf2);
      rdc(8'hd6, 8'hff);
      wr(8'h55, 8'h5a);
      rdc(8'h55, 8'h00);
      for (i = 0; i < 6; i = i + 1)
      begin
         exp_g = {$random(seed)} % 11;
         wr(8'haa, {3'h0, exp_g});
         rdc(8'haa, {3'h0, exp_g});
         #1 chk({3'h0, sixth}, {3'h0, exp_g});
      end
      $display("test registers done");
      md(16'h0000, 1'b0);
      wr(8'hb1, 8'h04);
      wr(8'haa, 8'h0a);
      exp_g = 5'h0a;
      md(16'h0000, 1'b1);
      md(16'he000, 1'b1);
      md(16'hdfff, 1'b1);
      wr(8'haa, 8'h00);
      exp_g = 5'h00;
      md(16'hffff, 1'b1);
      for (i = 0; i < 24; i = i + 1)
      begin
         {hs, ls} = $random(seed);
         wr(8'hb3, {hs, ls, 4'h2});
         d = $random(seed);
         md(d, 1'b1);
      end
      $display("test agc done");
      wr(8'h80, 8'h01);
      wr(8'hd6, 8'h01);
      az(6'h3f);
      #1 chk(restarts[7:0], 8'h01);
      wr(8'h80, 8'h00);
      az(6'h1f);
      #1 chk(restarts[7:0], 8'h01);
      chk({7'h0, follows}, 8'h01);
      wr(8'hd6, 8'h00);
      az(6'h00);
      $display("test auto-zero done");
      wr(8'hb3, 8'hf1);
      fl(1'b1);
      chk({7'h0, status}, 8'h01);
      wr(8'hb3, 8'hf2);
      fl(1'b0);
      chk({7'h0, status}, 8'h01);
      fl(1'b0);
      chk({7'h0, status}, 8'h00);
      chk(events[7:0], 8'h02);
      $display("test persistence done");
      complete_run;
   end
endmodule
bind sgc_cfg sgc_cfg_props #(.AZ_CYCLES(AZ_CYCLES)) i_sgc_cfg_props (
   .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .reg_wr(reg_wr),
   .meas_done(meas_done), .spectral_gain_code_ff(spectral_gain_code_ff),
   .sixth_gain_code_ff(sixth_gain_code_ff),
   .sixth_follows_ff(sixth_follows_ff), .flicker_event_ff(flicker_event_ff),
   .autozero_busy_ff(autozero_busy_ff), .autozero_chan_ff(autozero_chan_ff),
   .flicker_restart_ff(flicker_restart_ff));
`default_nettype wire
